// ### design/spt_defs.svh
// Constants for the sample phase timing generator.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SPT_DEFS_SVH
`define SPT_DEFS_SVH

// Phase selection reset value: 11 in six channel, X1 in three channel
`define SPT_SEL_RST 2'h3
// Top phase selection; the phase shift is its distance from the selection
`define SPT_SEL_TOP 2'h3
// Counter state loaded by the line sync reset
`define SPT_CNT_SYNC 2'h0
// Counter state loaded by the hold edge in the self phased mode
`define SPT_CNT_HOLD 2'h2
// Counter reset value
`define SPT_CNT_RST 2'h0
// Bit of the shifted counter that carries the phase signal
`define SPT_PH_BIT 1
// Fixed low half of the three channel selection
`define SPT_SEL3_LO 1'b1
// Converter data width and zero value
`define SPT_DW 10
`define SPT_DZERO 10'h000

`endif

// ### design/spt_pkg.sv
// Types for the sample phase timing generator.
// Assumes the constants header is included where numbers are needed.
package spt_pkg;

  typedef enum logic [2:0] {
    SH_SELF_PHASED_MODE = 3'h0,
    SH_DIRECT_WINDOW_MODE = 3'h1,
    SH_PHASE_CLOCKED_MODE = 3'h2,
    SH_STROBE_GATED_MODE = 3'h3,
    CDS_PHASE_CLOCKED_MODE = 3'h4,
    CDS_STROBE_GATED_MODE = 3'h5
  } spt_mode_e;

  typedef enum logic [1:0] {
    CFG_6CH_ADC_RATE = 2'h0,
    CFG_6CH_PIXEL_RATE = 2'h1,
    CFG_3CH_PIXEL_RATE = 2'h2
  } spt_clk_cfg_e;

endpackage : spt_pkg

// ### design/spt_rise_det.sv
// Rising edge detector with selectable capture edge.
// Assumes the input is synchronous to the master clock.
`timescale 1ns/1ps
module spt_rise_det (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic edge_sel_in,
  input wire logic d_in,
  output logic rise_out
);

  logic pos_ff;
  logic neg_ff;
  logic lvl_ff;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pos_ff <= 1'b0;
    end else if (ce_in) begin
      pos_ff <= d_in;
    end
  end

  // Falling edge capture, retimed below onto the rising edge
  always_ff @(negedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      neg_ff <= 1'b0;
    end else if (ce_in) begin
      neg_ff <= d_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lvl_ff <= 1'b0;
    end else if (ce_in) begin
      lvl_ff <= edge_sel_in ? neg_ff : pos_ff;
    end
  end

  assign rise_out = (edge_sel_in ? neg_ff : pos_ff) & ~lvl_ff;

endmodule : spt_rise_det

// ### design/spt_white_calc.sv
// White value computation: line maximum minus black average vs target.
// Assumes pixel values arrive already window averaged, one per valid.
`timescale 1ns/1ps
`include "spt_defs.svh"
module spt_white_calc (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic line_start_in,
  input wire logic pix_valid_in,
  input wire logic white_pix_in,
  input wire logic [`SPT_DW-1:0] adc_value_in,
  input wire logic [`SPT_DW-1:0] black_avg_in,
  input wire logic black_sub_en_in,
  input wire logic [`SPT_DW-1:0] target_in,
  input wire logic loop_done_in,
  output logic [`SPT_DW-1:0] corrected_white_value_out,
  output logic below_target_out,
  output logic result_valid_out,
  output logic black_rerun_out
);

  logic [`SPT_DW-1:0] max_ff;
  logic [`SPT_DW-1:0] nxt_corr;

  // Clamp at zero so a dark line never wraps to a huge white value
  always_comb begin
    nxt_corr = max_ff;
    if (black_sub_en_in) begin
      nxt_corr = (max_ff > black_avg_in) ? max_ff - black_avg_in : `SPT_DZERO;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      max_ff <= `SPT_DZERO;
    end else if (ce_in) begin
      if (line_start_in) begin
        max_ff <= `SPT_DZERO;
      end else if (pix_valid_in && white_pix_in && adc_value_in > max_ff) begin
        max_ff <= adc_value_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      corrected_white_value_out <= `SPT_DZERO;
      below_target_out <= 1'b0;
      result_valid_out <= 1'b0;
    end else if (ce_in) begin
      result_valid_out <= line_start_in;
      if (line_start_in) begin
        corrected_white_value_out <= nxt_corr;
        below_target_out <= nxt_corr < target_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      black_rerun_out <= 1'b0;
    end else if (ce_in) begin
      black_rerun_out <= loop_done_in;
    end
  end

endmodule : spt_white_calc

// ### design/spt_timing_gen.sv
// Sample phase timing generator: phase state machine and strobe gating.
// Assumes all inputs are synchronous to SYS_CLK_IN, one tick per quarter
// pixel, and that white calculation inputs come from the data path.
`timescale 1ns/1ps
`include "spt_defs.svh"

// Notes on behaviour
// - Clamp strobe is reference strobe AND phase
// - Sample strobe is signal strobe AND inverted phase
// - Window opens on sample rise, closes hold
// - Window qualified by low phase gives sample
// - Six channel: two converter cycles, four phases
// - Three channel: one converter cycle, two phases
// - Three clocking configurations are supported
// - Converter rate: line sync reloads phase machine
// - Line sync captured on selectable clock edge
// - Phase selection resets to 11, X1
// - Lower selections shift timing earlier by quarters
// - White value is maximum minus black average
// - Black loop reruns once after white loop
// - Without correlated sampling, reference strobe ignored
// - Self-phased mode phases from hold, no sync
module spt_timing_gen (
  input wire logic SYS_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CLK_EN_IN,
  input wire logic [2:0] MODE_IN,
  input wire logic [1:0] CLK_CFG_IN,
  input wire logic SYNC_EDGE_SEL_IN,
  input wire logic [1:0] PHASE_SEL_IN,
  input wire logic PHASE_SEL_WR_IN,
  input wire logic LINE_SYNC_IN,
  input wire logic REF_STROBE_IN,
  input wire logic SIG_STROBE_IN,
  input wire logic SAMPLE_IN,
  input wire logic HOLD_IN,
  input wire logic PIX_VALID_IN,
  input wire logic WHITE_PIX_IN,
  input wire logic [9:0] ADC_VALUE_IN,
  input wire logic [9:0] BLACK_AVG_IN,
  input wire logic BLACK_SUB_EN_IN,
  input wire logic [9:0] WHITE_TARGET_IN,
  input wire logic WHITE_LOOP_DONE_IN,
  output logic CLAMP_STROBE_OUT,
  output logic SAMPLE_STROBE_OUT,
  output logic PHASE_SIGNAL_OUT,
  output logic CONVERTER_CLOCK_OUT,
  output logic SAMPLE_WINDOW_OUT,
  output logic [1:0] PHASE_SEL_OUT,
  output logic [9:0] CORRECTED_WHITE_OUT,
  output logic BELOW_TARGET_OUT,
  output logic WHITE_RESULT_VALID_OUT,
  output logic BLACK_RERUN_OUT
);

  spt_pkg::spt_mode_e mode;
  spt_pkg::spt_clk_cfg_e cfg;
  logic three_ch;
  logic [1:0] sel_ff;
  logic [1:0] sel_eff;
  logic [1:0] cnt_ff;
  logic [1:0] pos;
  logic ph;
  logic sync_rise;
  logic sample_rise;
  logic hold_rise;
  logic win_ff;
  logic nxt_clamp;
  logic nxt_sample;

  assign mode = spt_pkg::spt_mode_e'(MODE_IN);
  assign cfg = spt_pkg::spt_clk_cfg_e'(CLK_CFG_IN);
  assign three_ch = (cfg == spt_pkg::CFG_3CH_PIXEL_RATE);

  ////////////////////////////////////////////////////////////////////////
  // Edge capture of line sync and sample/hold inputs

  spt_rise_det u_sync (
    .clk_in(SYS_CLK_IN),
    .arst_n_in(ARST_N_IN),
    .ce_in(CLK_EN_IN),
    .edge_sel_in(SYNC_EDGE_SEL_IN),
    .d_in(LINE_SYNC_IN),
    .rise_out(sync_rise)
  );

  spt_rise_det u_sample (
    .clk_in(SYS_CLK_IN),
    .arst_n_in(ARST_N_IN),
    .ce_in(CLK_EN_IN),
    .edge_sel_in(1'b0),
    .d_in(SAMPLE_IN),
    .rise_out(sample_rise)
  );

  spt_rise_det u_hold (
    .clk_in(SYS_CLK_IN),
    .arst_n_in(ARST_N_IN),
    .ce_in(CLK_EN_IN),
    .edge_sel_in(1'b0),
    .d_in(HOLD_IN),
    .rise_out(hold_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // Phase selection and phase state machine

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sel_ff <= `SPT_SEL_RST;
    end else if (CLK_EN_IN && PHASE_SEL_WR_IN) begin
      sel_ff <= PHASE_SEL_IN;
    end
  end

  // Three channel mode ignores the upper selection bit
  assign sel_eff = three_ch ? {sel_ff[0], `SPT_SEL3_LO} : sel_ff;

  // Reload wins over counting; the hold edge only steers self phased mode
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cnt_ff <= `SPT_CNT_RST;
    end else if (CLK_EN_IN) begin
      if (mode == spt_pkg::SH_SELF_PHASED_MODE && hold_rise) begin
        cnt_ff <= `SPT_CNT_HOLD;
      end else if (mode != spt_pkg::SH_SELF_PHASED_MODE && sync_rise &&
                   cfg == spt_pkg::CFG_6CH_ADC_RATE) begin
        cnt_ff <= `SPT_CNT_SYNC;
      end else begin
        cnt_ff <= cnt_ff + 2'h1;
      end
    end
  end

  // Each step below the top selection moves the phase a quarter earlier
  assign pos = cnt_ff + (`SPT_SEL_TOP - sel_eff);
  assign ph = ~pos[`SPT_PH_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Sample control window

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      win_ff <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (hold_rise) begin
        win_ff <= 1'b0;
      end else if (sample_rise) begin
        win_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Strobe gating, registered so no decode glitch reaches the outputs

  always_comb begin
    nxt_clamp = 1'b0;
    nxt_sample = 1'b0;
    unique case (mode)
      spt_pkg::CDS_STROBE_GATED_MODE: begin
        nxt_clamp = REF_STROBE_IN & ph;
        nxt_sample = SIG_STROBE_IN & ~ph;
      end
      spt_pkg::SH_STROBE_GATED_MODE: begin
        nxt_sample = SIG_STROBE_IN & ~ph;
      end
      spt_pkg::CDS_PHASE_CLOCKED_MODE: begin
        nxt_clamp = ph;
        nxt_sample = ~ph;
      end
      spt_pkg::SH_PHASE_CLOCKED_MODE: begin
        nxt_sample = ~ph;
      end
      spt_pkg::SH_DIRECT_WINDOW_MODE,
      spt_pkg::SH_SELF_PHASED_MODE: begin
        nxt_sample = win_ff & ~ph;
      end
      default: begin
        nxt_clamp = 1'b0;
        nxt_sample = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      CLAMP_STROBE_OUT <= 1'b0;
      SAMPLE_STROBE_OUT <= 1'b0;
      PHASE_SIGNAL_OUT <= 1'b0;
      SAMPLE_WINDOW_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      CLAMP_STROBE_OUT <= nxt_clamp;
      SAMPLE_STROBE_OUT <= nxt_sample;
      PHASE_SIGNAL_OUT <= ph;
      SAMPLE_WINDOW_OUT <= win_ff;
    end
  end

  // Six channel: two converter cycles per pixel; three channel: one
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      CONVERTER_CLOCK_OUT <= 1'b0;
      PHASE_SEL_OUT <= `SPT_SEL_RST;
    end else if (CLK_EN_IN) begin
      CONVERTER_CLOCK_OUT <= three_ch ? ~cnt_ff[1] : ~cnt_ff[0];
      PHASE_SEL_OUT <= sel_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // White value computation

  spt_white_calc u_white (
    .clk_in(SYS_CLK_IN),
    .arst_n_in(ARST_N_IN),
    .ce_in(CLK_EN_IN),
    .line_start_in(sync_rise),
    .pix_valid_in(PIX_VALID_IN),
    .white_pix_in(WHITE_PIX_IN),
    .adc_value_in(ADC_VALUE_IN),
    .black_avg_in(BLACK_AVG_IN),
    .black_sub_en_in(BLACK_SUB_EN_IN),
    .target_in(WHITE_TARGET_IN),
    .loop_done_in(WHITE_LOOP_DONE_IN),
    .corrected_white_value_out(CORRECTED_WHITE_OUT),
    .below_target_out(BELOW_TARGET_OUT),
    .result_valid_out(WHITE_RESULT_VALID_OUT),
    .black_rerun_out(BLACK_RERUN_OUT)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  a_clamp_gate: assert property (
    CLK_EN_IN && mode == spt_pkg::CDS_STROBE_GATED_MODE |=>
      CLAMP_STROBE_OUT == ($past(REF_STROBE_IN) && PHASE_SIGNAL_OUT))
    else $error("clamp strobe mismatch");

  a_clamp_and: assert property (
    CLK_EN_IN && mode == spt_pkg::CDS_STROBE_GATED_MODE && !REF_STROBE_IN |=>
      !CLAMP_STROBE_OUT)
    else $error("clamp without reference strobe");

  a_sample_and: assert property (
    CLK_EN_IN && mode == spt_pkg::CDS_STROBE_GATED_MODE |=>
      SAMPLE_STROBE_OUT == ($past(SIG_STROBE_IN) && !PHASE_SIGNAL_OUT))
    else $error("sample strobe mismatch");

  a_window_open: assert property (
    CLK_EN_IN && sample_rise && !hold_rise ##1 CLK_EN_IN |=> SAMPLE_WINDOW_OUT)
    else $error("window did not open");

  a_window_gate: assert property (
    $past(mode) == spt_pkg::SH_DIRECT_WINDOW_MODE && SAMPLE_STROBE_OUT && $past(CLK_EN_IN) |->
      $past(win_ff) && !PHASE_SIGNAL_OUT)
    else $error("sample outside window or high phase");

  a_conv_six: assert property (
    CLK_EN_IN && cfg == spt_pkg::CFG_6CH_PIXEL_RATE ##1
      CLK_EN_IN && cfg == spt_pkg::CFG_6CH_PIXEL_RATE |=>
      CONVERTER_CLOCK_OUT != $past(CONVERTER_CLOCK_OUT))
    else $error("six channel converter clock not toggling");

  a_conv_three: assert property (
    CLK_EN_IN && three_ch |=>
      PHASE_SIGNAL_OUT == (CONVERTER_CLOCK_OUT ~^ $past(sel_ff[0])))
    else $error("three channel phase not tied to converter clock");

  a_ref_ignored: assert property (
    CLK_EN_IN && mode != spt_pkg::CDS_STROBE_GATED_MODE &&
      mode != spt_pkg::CDS_PHASE_CLOCKED_MODE |=> !CLAMP_STROBE_OUT)
    else $error("clamp strobe outside correlated sampling");

  a_rerun_pulse: assert property (
    CLK_EN_IN && WHITE_LOOP_DONE_IN |=> BLACK_RERUN_OUT)
    else $error("black rerun not requested");

  a_sync_reload: assert property (
    CLK_EN_IN && sync_rise && cfg == spt_pkg::CFG_6CH_ADC_RATE &&
      mode != spt_pkg::SH_SELF_PHASED_MODE |=> cnt_ff == `SPT_CNT_SYNC)
    else $error("line sync did not reload phase counter");

  a_hold_reload: assert property (
    CLK_EN_IN && hold_rise && mode == spt_pkg::SH_SELF_PHASED_MODE |=>
      cnt_ff == `SPT_CNT_HOLD)
    else $error("hold edge did not reload phase counter");

  a_sel_stable: assert property (
    !(CLK_EN_IN && PHASE_SEL_WR_IN) |=> $stable(sel_ff))
    else $error("phase selection changed without write");

  c_cds_clamp: cover property (mode == spt_pkg::CDS_STROBE_GATED_MODE && CLAMP_STROBE_OUT);
  c_window_sample: cover property (mode == spt_pkg::SH_DIRECT_WINDOW_MODE && SAMPLE_STROBE_OUT);
  c_sync_reload: cover property (sync_rise && cfg == spt_pkg::CFG_6CH_ADC_RATE);
  c_white_result: cover property (WHITE_RESULT_VALID_OUT && BELOW_TARGET_OUT);
  c_self_reload: cover property (hold_rise && mode == spt_pkg::SH_SELF_PHASED_MODE);

endmodule : spt_timing_gen

// ### dv/spt_host_model.sv
// Host timing model: line sync, sample and hold pulses for the generator.
// Assumes one-cycle requests raised just after a falling clock edge.
`timescale 1ns/1ps
module spt_host_model (
  input wire logic clk_in,
  input wire logic sync_req_in,
  input wire logic smp_req_in,
  input wire logic hold_req_in,
  output logic line_sync_out,
  output logic sample_out,
  output logic hold_out
);
  logic [2:0] sync_cnt_ff;
  initial begin
    sync_cnt_ff = 3'h0;
    line_sync_out = 1'b0;
    sample_out = 1'b0;
    hold_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Sync high four cycles, low three at least; busy requests are dropped
  always @(negedge clk_in) begin
    if (sync_req_in && sync_cnt_ff == 3'h0) begin
      sync_cnt_ff <= 3'h6;
      line_sync_out <= 1'b1;
    end else begin
      sync_cnt_ff <= (sync_cnt_ff == 3'h0) ? 3'h0 : sync_cnt_ff - 3'h1;
      line_sync_out <= (sync_cnt_ff > 3'h3);
    end
  end
  // Only the rising edges matter, so one-cycle pulses suffice
  always @(negedge clk_in) begin
    sample_out <= smp_req_in;
    hold_out <= hold_req_in;
  end
endmodule : spt_host_model

// ### dv/spt_timing_gen_tb_top.sv
// Self-checking bench for the sample phase timing generator.
// Assumes the host model makes line sync, sample and hold pulses.
`timescale 1ns/1ps
`include "spt_defs.svh"
module spt_timing_gen_tb_top;
  logic clk, rst_n, en, edge_sel, sel_wr, ref_s, sig_s, pv, wp, bse, done, ec, es;
  logic sreq, sm_req, h_req, ls, smp, hld, clamp, samp, ph, cclk, win, bt, rv, rerun;
  logic [2:0] mode;
  logic [1:0] cfg, sel, sel_o;
  logic [9:0] adc, blk, targ, cw;
  logic [3:0] pa, pb, pc, ca;
  int failures, checks_done, cyc, n;
  spt_pkg::spt_mode_e gm [4] = '{spt_pkg::CDS_STROBE_GATED_MODE,
    spt_pkg::CDS_STROBE_GATED_MODE, spt_pkg::SH_STROBE_GATED_MODE,
    spt_pkg::CDS_PHASE_CLOCKED_MODE};
  logic [3:0] gr = 4'h5, gs = 4'h7, pw = 4'hb;
  logic [9:0] px [4] = '{10'h12c, 10'h2bc, 10'h384, 10'h28a};
  logic [9:0] wb [3] = '{10'h064, 10'h320, 10'h064};
  logic [9:0] wt [3] = '{10'h258, 10'h258, 10'h2bd};
  logic [9:0] wc [3] = '{10'h258, 10'h000, 10'h2bc};
  logic [2:0] wbt = 3'h6, wbse = 3'h3;

  spt_timing_gen dut_u (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .CLK_EN_IN(en),
    .MODE_IN(mode), .CLK_CFG_IN(cfg), .SYNC_EDGE_SEL_IN(edge_sel),
    .PHASE_SEL_IN(sel), .PHASE_SEL_WR_IN(sel_wr), .LINE_SYNC_IN(ls),
    .REF_STROBE_IN(ref_s), .SIG_STROBE_IN(sig_s), .SAMPLE_IN(smp), .HOLD_IN(hld),
    .PIX_VALID_IN(pv), .WHITE_PIX_IN(wp), .ADC_VALUE_IN(adc), .BLACK_AVG_IN(blk),
    .BLACK_SUB_EN_IN(bse), .WHITE_TARGET_IN(targ), .WHITE_LOOP_DONE_IN(done),
    .CLAMP_STROBE_OUT(clamp), .SAMPLE_STROBE_OUT(samp), .PHASE_SIGNAL_OUT(ph),
    .CONVERTER_CLOCK_OUT(cclk), .SAMPLE_WINDOW_OUT(win), .PHASE_SEL_OUT(sel_o),
    .CORRECTED_WHITE_OUT(cw), .BELOW_TARGET_OUT(bt), .WHITE_RESULT_VALID_OUT(rv),
    .BLACK_RERUN_OUT(rerun));
  spt_host_model host_u (.clk_in(clk), .sync_req_in(sreq), .smp_req_in(sm_req),
    .hold_req_in(h_req), .line_sync_out(ls), .sample_out(smp), .hold_out(hld));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic print_verdict;
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  function automatic logic [2:0] tgl(input logic [3:0] p);
    tgl = (p[0] ^ p[1]) + (p[1] ^ p[2]) + (p[2] ^ p[3]) + (p[3] ^ p[0]);
  endfunction : tgl
  function automatic logic [3:0] rot(input logic [3:0] p, input int k);
    rot = 4'({p, p} >> k);
  endfunction : rot
  // Eight cycles a call keeps the free counter's alignment between calls
  task automatic pat(input logic [1:0] s, output logic [3:0] p, output logic [3:0] c);
    sel <= s;
    sel_wr <= 1'b1;
    tick(1);
    sel_wr <= 1'b0;
    tick(3);
    for (int i = 0; i < 4; i++) begin
      p[i] = ph;
      c[i] = cclk;
      tick(1);
    end
  endtask : pat
  task automatic spat(input int off, input logic use_hold, output logic [3:0] p);
    tick(off);
    if (use_hold) h_req <= 1'b1;
    else sreq <= 1'b1;
    tick(1);
    h_req <= 1'b0;
    sreq <= 1'b0;
    tick(8);
    for (int i = 0; i < 4; i++) begin
      p[i] = ph;
      tick(1);
    end
  endtask : spat
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    {rst_n, edge_sel, sel_wr, ref_s, sig_s, pv, wp, bse, done, sreq, sm_req, h_req} = '0;
    en = 1'b1;
    mode = spt_pkg::CDS_STROBE_GATED_MODE;
    cfg = spt_pkg::CFG_6CH_ADC_RATE;
    sel = 2'h3;
    {adc, blk, targ} = '0;
    tick(16);
    chk(sel_o, `SPT_SEL_RST);
    rst_n <= 1'b1;
    tick(2);
    chk(sel_o, `SPT_SEL_RST);
    spat(0, 1'b0, pa);
    spat(1, 1'b0, pb);
    spat(2, 1'b0, pc);
    chk(pb, pa);
    chk(pc, pa);
    chk(tgl(pa), 3'h2);
    // Line sync launched on a falling edge: both capture edges reload alike
    edge_sel <= 1'b1;
    spat(0, 1'b0, pb);
    edge_sel <= 1'b0;
    chk(pb, pa);
    pat(2'h3, pa, ca);
    chk(tgl(ca), 3'h4);
    for (int s = 0; s < 3; s++) begin
      pat(s[1:0], pb, ca);
      chk(pb, rot(pa, 3 - s));
      chk(sel_o, {8'h00, s[1:0]});
    end
    cfg <= spt_pkg::CFG_6CH_PIXEL_RATE;
    spat(0, 1'b0, pa);
    spat(1, 1'b0, pb);
    chk(pb == pa, 1'b0);
    cfg <= spt_pkg::CFG_3CH_PIXEL_RATE;
    pat(2'h3, pa, ca);
    chk(tgl(ca), 3'h2);
    pat(2'h1, pb, ca);
    chk(pb, pa);
    pat(2'h0, pc, ca);
    chk(pc, rot(pa, 2));
    pat(2'h2, pb, ca);
    chk(pb, pc);
    cfg <= spt_pkg::CFG_6CH_ADC_RATE;
    for (int k = 0; k < 4; k++) begin
      mode <= gm[k];
      // Level strobes stay constant across both phase halves of each step
      ref_s <= gr[k];
      sig_s <= gs[k];
      tick(3);
      repeat (4) begin
        ec = (k == 3) ? ph : (k < 2) & gr[k] & ph;
        es = (k == 3) ? ~ph : gs[k] & ~ph;
        chk(clamp, ec);
        chk(samp, es);
        tick(1);
      end
    end
    // Frozen enable must hold every flop, phase included
    en <= 1'b0;
    tick(2);
    pat(2'h3, pa, ca);
    chk(tgl(pa), 3'h0);
    en <= 1'b1;
    mode <= spt_pkg::SH_DIRECT_WINDOW_MODE;
    sm_req <= 1'b1;
    tick(1);
    sm_req <= 1'b0;
    tick(4);
    chk(win, 1'b1);
    n = 0;
    repeat (8) begin
      n += samp;
      tick(1);
    end
    chk(n[9:0], 10'h004);
    h_req <= 1'b1;
    tick(1);
    h_req <= 1'b0;
    tick(4);
    chk(win, 1'b0);
    chk(samp, 1'b0);
    {sm_req, h_req} <= 2'h3;
    tick(1);
    {sm_req, h_req} <= 2'h0;
    tick(4);
    chk(win, 1'b0);
    // Self-phased mode only on the converter-rate clock
    mode <= spt_pkg::SH_SELF_PHASED_MODE;
    spat(0, 1'b1, pa);
    spat(1, 1'b1, pb);
    spat(2, 1'b0, pc);
    chk(pb, pa);
    chk(pc, rot(pa, 3));
    mode <= spt_pkg::CDS_STROBE_GATED_MODE;
    sreq <= 1'b1;
    tick(1);
    sreq <= 1'b0;
    tick(12);
    for (int c = 0; c < 3; c++) begin
      blk <= wb[c];
      targ <= wt[c];
      bse <= wbse[c];
      for (int i = 0; i < 4; i++) begin
        adc <= px[i];
        wp <= pw[i];
        pv <= 1'b1;
        tick(1);
        pv <= 1'b0;
        tick(1);
      end
      sreq <= 1'b1;
      tick(1);
      sreq <= 1'b0;
      for (n = 0; n < 20 && rv !== 1'b1; n++) tick(1);
      chk(rv, 1'b1);
      chk(cw, wc[c]);
      chk(bt, wbt[c]);
      tick(3);
    end
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    chk(rerun, 1'b1);
    tick(1);
    chk(rerun, 1'b0);
    print_verdict();
  end
endmodule : spt_timing_gen_tb_top
